// ===== cdp_config_front.sv
`timescale 1ns/1ps
`include "cdp_defs.svh"

module cdp_config_front
  import cdp_pkg::*;
#(
  parameter int FAST_POR_CYCLES = `CDP_FAST_POR_CYCLES,
  parameter int STD_POR_CYCLES  = `CDP_STD_POR_CYCLES,
  parameter int FRAME_BYTES     = `CDP_FRAME_BYTES,
  parameter int DATA_W          = `CDP_DATA_W
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 core_supply_ok,
  input  wire logic                 pll_supply_ok,
  input  wire logic                 io_bank_supply_ok,
  input  wire logic [`CDP_SEL_W-1:0] scheme_select,
  input  wire logic                 config_request_n,
  input  wire logic                 remote_update_option,
  input  wire logic                 compression_option,
  input  wire logic                 cfg_strobe,
  input  wire logic [DATA_W-1:0]    cfg_data,
  output logic                      config_status_n_out,
  output logic                      config_status_n_oe,
  output logic                      config_complete_out,
  output logic                      config_complete_oe,
  output logic                      cell_wr_en,
  output logic [DATA_W-1:0]         cell_wr_data,
  output logic                      config_ready,
  output logic                      por_fast,
  output logic [2:0]                scheme_code,
  output logic                      compression_active,
  output logic                      compression_refused,
  output logic                      remote_update_internal,
  output logic                      remote_update_external,
  output logic                      brownout_seen,
  output logic                      stray_data
);

  localparam int SYNC_W = 3 + `CDP_SEL_W + 2 + DATA_W;
  localparam logic [`CDP_POR_CNT_W-1:0] FAST_LAST = `CDP_POR_CNT_W'(FAST_POR_CYCLES - 1);
  localparam logic [`CDP_POR_CNT_W-1:0] STD_LAST  = `CDP_POR_CNT_W'(STD_POR_CYCLES - 1);
  localparam logic [`CDP_FRAME_CNT_W-1:0] FRAME_LAST = `CDP_FRAME_CNT_W'(FRAME_BYTES - 1);

  // Every pin passes two flops; only the second stage is read below.
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {core_supply_ok, pll_supply_ok, io_bank_supply_ok, scheme_select,
                 config_request_n, cfg_strobe, cfg_data};
      sync_b <= sync_a;
    end
  end

  wire                  s_core   = sync_b[SYNC_W-1];
  wire                  s_pll    = sync_b[SYNC_W-2];
  wire                  s_io     = sync_b[SYNC_W-3];
  wire [`CDP_SEL_W-1:0] s_sel    = sync_b[DATA_W+2 +: `CDP_SEL_W];
  wire                  s_req_n  = sync_b[DATA_W+1];
  wire                  s_strobe = sync_b[DATA_W];
  wire [DATA_W-1:0]     s_data   = sync_b[DATA_W-1:0];

  // The option inputs are pins too, so they pass their own two-flop stage.
  logic [1:0] opt_a;
  logic [1:0] opt_b;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      opt_a <= 2'h0;
      opt_b <= 2'h0;
    end else begin
      opt_a <= {remote_update_option, compression_option};
      opt_b <= opt_a;
    end
  end

  wire s_remote   = opt_b[1];
  wire s_compress = opt_b[0];

  cdp_state_t                   state;
  cdp_state_t                   next_state;
  cdp_scheme_t                  scheme;
  logic                         fast_sel;
  logic [`CDP_POR_CNT_W-1:0]    por_cnt;
  logic [`CDP_FRAME_CNT_W-1:0]  frame_cnt;
  logic                         strobe_d;
  logic                         od_level;
  logic                         exp_valid;
  logic [DATA_W-1:0]            exp_data;

  wire strobe_rise   = s_strobe & ~strobe_d;
  wire all_supplies  = s_core & s_pll & s_io;
  wire in_config     = (state == CDP_ST_CONFIG);
  wire in_por        = (state == CDP_ST_PWR_WAIT) | (state == CDP_ST_POR_TIME);
  wire take_strobe   = strobe_rise & in_config;

  // The reset time follows the strap caught when the supplies came good.
  wire [`CDP_POR_CNT_W-1:0] por_last = fast_sel ? FAST_LAST : STD_LAST;
  wire por_expired  = (por_cnt == por_last);
  wire frame_end    = exp_valid & (frame_cnt == FRAME_LAST);

  // Only the serial schemes feed the expander; others pass data through.
  wire scheme_can_expand = (scheme == CDP_SCH_AS) | (scheme == CDP_SCH_PS);
  wire expand_on         = s_compress & scheme_can_expand;
  wire expand_refused    = s_compress & ~scheme_can_expand;

  wire ru_int_scheme = (scheme == CDP_SCH_AS) | (scheme == CDP_SCH_AP);
  wire ru_ext_scheme = (scheme == CDP_SCH_PS) | (scheme == CDP_SCH_FPP);
  wire ru_int        = s_remote & ru_int_scheme;
  wire ru_ext        = s_remote & ru_ext_scheme;

  wire core_drop = ~s_core & ~in_por;
  wire pll_drop  = ~s_pll & ~in_por;
  wire brownout  = core_drop | pll_drop;

  always_comb begin
    next_state = state;
    unique case (state)
      CDP_ST_PWR_WAIT: begin
        if (all_supplies) begin
          next_state = CDP_ST_POR_TIME;
        end
      end
      CDP_ST_POR_TIME: begin
        if (!all_supplies) begin
          next_state = CDP_ST_PWR_WAIT;
        end else if (por_expired) begin
          next_state = CDP_ST_CFG_RESET;
        end
      end
      CDP_ST_CFG_RESET: begin
        if (brownout) begin
          next_state = CDP_ST_PWR_WAIT;
        end else if (s_req_n) begin
          next_state = CDP_ST_CONFIG;
        end
      end
      CDP_ST_CONFIG: begin
        if (brownout) begin
          next_state = CDP_ST_PWR_WAIT;
        end else if (!s_req_n) begin
          next_state = CDP_ST_CFG_RESET;
        end else if (frame_end) begin
          next_state = CDP_ST_DONE;
        end
      end
      CDP_ST_DONE: begin
        if (brownout) begin
          next_state = CDP_ST_PWR_WAIT;
        end else if (!s_req_n) begin
          next_state = CDP_ST_CFG_RESET;
        end
      end
      default: begin
        next_state = CDP_ST_PWR_WAIT;
      end
    endcase
  end

  wire next_status_oe   = (next_state == CDP_ST_PWR_WAIT) |
                          (next_state == CDP_ST_POR_TIME) |
                          (next_state == CDP_ST_CFG_RESET);
  wire next_complete_oe = (next_state != CDP_ST_DONE);
  wire catch_strap      = (state == CDP_ST_PWR_WAIT) & all_supplies;
  wire next_ready       = (next_state == CDP_ST_CONFIG);
  wire sticky_clear     = (state == CDP_ST_CFG_RESET) & s_req_n;
  wire stray_edge       = strobe_rise & ~in_config;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= CDP_ST_PWR_WAIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scheme <= CDP_SCH_AS;
    end else if (catch_strap) begin
      scheme <= cdp_scheme_t'(s_sel[`CDP_SEL_SCHEME_MSB:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fast_sel <= 1'b0;
    end else if (catch_strap) begin
      fast_sel <= s_sel[`CDP_SEL_FAST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || state != CDP_ST_POR_TIME) begin
      por_cnt <= '0;
    end else if (!por_expired) begin
      por_cnt <= por_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !in_config) begin
      frame_cnt <= '0;
    end else if (exp_valid) begin
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  // Held low during power-up and any reset; status is released in CONFIG and DONE, complete only in DONE.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      config_status_n_oe <= 1'b1;
      config_complete_oe <= 1'b1;
    end else begin
      config_status_n_oe <= next_status_oe;
      config_complete_oe <= next_complete_oe;
    end
  end

  // The pins are open drain, so the level stays low and only the enables move.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      od_level <= 1'b0;
    end else begin
      od_level <= 1'b0;
    end
  end

  assign config_status_n_out = od_level;
  assign config_complete_out = od_level;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= s_strobe;
    end
  end

  // The sender's data are sampled on the synchronised strobe edge, so the data
  // must settle at the pins before the strobe rises.
  cdp_expander #(
    .DATA_W    (DATA_W)
  ) u_expander (
    .clk       (clk),
    .nrst      (nrst),
    .clear     (~in_config),
    .enable    (expand_on),
    .in_valid  (take_strobe),
    .in_data   (s_data),
    .out_valid (exp_valid),
    .out_data  (exp_data)
  );

  assign cell_wr_en   = exp_valid;
  assign cell_wr_data = exp_data;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      config_ready <= 1'b0;
      por_fast     <= 1'b0;
      scheme_code  <= 3'h0;
    end else begin
      config_ready <= next_ready;
      por_fast     <= fast_sel;
      scheme_code  <= scheme;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      compression_active     <= 1'b0;
      compression_refused    <= 1'b0;
      remote_update_internal <= 1'b0;
      remote_update_external <= 1'b0;
    end else begin
      compression_active     <= expand_on;
      compression_refused    <= expand_refused;
      remote_update_internal <= ru_int & ~in_por;
      remote_update_external <= ru_ext & ~in_por;
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      brownout_seen <= 1'b0;
    end else if (brownout) begin
      brownout_seen <= 1'b1;
    end else if (sticky_clear) begin
      brownout_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stray_data <= 1'b0;
    end else if (stray_edge) begin
      stray_data <= 1'b1;
    end else if (sticky_clear) begin
      stray_data <= 1'b0;
    end
  end

endmodule : cdp_config_front

// ===== cdp_defs.svh
`ifndef CDP_DEFS_SVH
`define CDP_DEFS_SVH

`define CDP_CLK_HZ           10000000
`define CDP_FAST_POR_US      4000
`define CDP_STD_POR_US       100000
`define CDP_FAST_POR_CYCLES  ((`CDP_FAST_POR_US * (`CDP_CLK_HZ / 1000000)))
`define CDP_STD_POR_CYCLES   ((`CDP_STD_POR_US * (`CDP_CLK_HZ / 1000000)))
`define CDP_POR_CNT_W        20

`define CDP_SEL_W            4
`define CDP_SEL_FAST_BIT     3
`define CDP_SEL_SCHEME_MSB   2
`define CDP_SCHEME_AS        3'h0
`define CDP_SCHEME_AP        3'h1
`define CDP_SCHEME_PS        3'h2
`define CDP_SCHEME_FPP       3'h3
`define CDP_SCHEME_JTAG      3'h4

`define CDP_DATA_W           8
`define CDP_ESC_BYTE         8'h00
`define CDP_RUN_W            2
`define CDP_FRAME_BYTES      1024
`define CDP_FRAME_CNT_W      16

`endif

// ===== cdp_pkg.sv
`include "cdp_defs.svh"

package cdp_pkg;

  typedef enum logic [4:0] {
    CDP_ST_PWR_WAIT  = 5'b00001,
    CDP_ST_POR_TIME  = 5'b00010,
    CDP_ST_CFG_RESET = 5'b00100,
    CDP_ST_CONFIG    = 5'b01000,
    CDP_ST_DONE      = 5'b10000
  } cdp_state_t;

  typedef enum logic [2:0] {
    CDP_SCH_AS   = `CDP_SCHEME_AS,
    CDP_SCH_AP   = `CDP_SCHEME_AP,
    CDP_SCH_PS   = `CDP_SCHEME_PS,
    CDP_SCH_FPP  = `CDP_SCHEME_FPP,
    CDP_SCH_JTAG = `CDP_SCHEME_JTAG
  } cdp_scheme_t;

  typedef enum logic [1:0] {
    CDP_DS_LIT = 2'b01,
    CDP_DS_CNT = 2'b10
  } cdp_dstate_t;

endpackage : cdp_pkg

// ===== cdp_expander.sv
`timescale 1ns/1ps
`include "cdp_defs.svh"

module cdp_expander
  import cdp_pkg::*;
#(
  parameter int DATA_W = `CDP_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clear,
  input  wire logic              enable,
  input  wire logic              in_valid,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   out_valid,
  output logic [DATA_W-1:0]      out_data
);

  localparam logic [DATA_W-1:0] ESC = `CDP_ESC_BYTE;

  cdp_dstate_t              state;
  cdp_dstate_t              next_state;
  logic [`CDP_RUN_W-1:0]    run_left;
  logic [`CDP_RUN_W-1:0]    next_run_left;
  logic                     next_out_valid;
  logic [DATA_W-1:0]        next_out_data;

  // The first zero of a run goes out with the count byte itself, so a run of
  // four takes four cycles; no input is held back, and a byte taken sooner overwrites one of its zeros.
  always_comb begin
    next_state     = state;
    next_run_left  = run_left;
    next_out_valid = 1'b0;
    next_out_data  = out_data;
    if (run_left != '0) begin
      next_out_valid = 1'b1;
      next_out_data  = ESC;
      next_run_left  = run_left - 1'b1;
    end
    if (in_valid) begin
      if (!enable) begin
        next_out_valid = 1'b1;
        next_out_data  = in_data;
      end else begin
        unique case (state)
          CDP_DS_LIT: begin
            if (in_data == ESC) begin
              next_state = CDP_DS_CNT;
            end else begin
              next_out_valid = 1'b1;
              next_out_data  = in_data;
            end
          end
          CDP_DS_CNT: begin
            next_state     = CDP_DS_LIT;
            next_out_valid = 1'b1;
            next_out_data  = ESC;
            next_run_left  = in_data[`CDP_RUN_W-1:0];
          end
          default: begin
            next_state = CDP_DS_LIT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      state     <= CDP_DS_LIT;
      run_left  <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      state     <= next_state;
      run_left  <= next_run_left;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

endmodule : cdp_expander

// ===== cdp_host_model.sv
`timescale 1ns/1ps
module cdp_host_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       send,
  input  wire logic       slow,
  input  wire logic [7:0] byte_in,
  output logic            cfg_strobe,
  output logic [7:0]      cfg_data,
  output logic            busy
);
  logic [3:0] step;
  wire        last_step = step == (slow ? 4'hF : 4'h7);
  assign busy = step != 4'h0;
  // The host never waits on the device; the slow setting only widens the gap.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      step       <= 4'h0;
      cfg_strobe <= 1'b0;
      cfg_data   <= 8'hA5;
    end else if (!busy) begin
      if (send) begin
        step     <= 4'h1;
        cfg_data <= byte_in;
      end
    end else begin
      step       <= last_step ? 4'h0 : step + 4'h1;
      cfg_strobe <= step == 4'h2 || step == 4'h3;
      // Past the hold time the bus shows garbage, never the old byte.
      if (step == 4'h6) cfg_data <= ~cfg_data;
    end
  end
endmodule : cdp_host_model

// ===== cdp_config_front_assertions.sv
`timescale 1ns/1ps
module cdp_config_front_chk
  import cdp_pkg::*;
#(
  parameter int FAST_POR_CYCLES = 20,
  parameter int STD_POR_CYCLES  = 50,
  parameter int DATA_W          = 8
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              core_supply_ok,
  input wire logic              pll_supply_ok,
  input wire logic              config_request_n,
  input wire logic              remote_update_option,
  input wire logic              cfg_strobe,
  input wire logic [DATA_W-1:0] cfg_data,
  input wire logic              config_status_n_oe,
  input wire logic              config_complete_oe,
  input wire logic              cell_wr_en,
  input wire logic [DATA_W-1:0] cell_wr_data,
  input wire logic              config_ready,
  input wire logic              por_fast,
  input wire logic [2:0]        scheme_code,
  input wire logic              compression_active,
  input wire logic              remote_update_internal,
  input wire logic              remote_update_external
);
  int unsigned run;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles of good core and PLL supply; no release may come sooner than the reset time.
  always_ff @(posedge clk) begin
    if (!nrst || !core_supply_ok || !pll_supply_ok) begin
      run <= 32'h0;
    end else if (run < 32'hFFFFF) begin
      run <= run + 32'h1;
    end
  end
  AST_POR_TIME: assert property ($fell(config_status_n_oe) |->
    run > (por_fast ? FAST_POR_CYCLES : STD_POR_CYCLES)) else $error("status released early");
  AST_REQ_HOLDS: assert property (!config_request_n [*5] |->
    config_status_n_oe && config_complete_oe && !config_ready) else $error("reset not held");
  AST_REQ_RELEASE: assert property ($rose(config_ready) |->
    !config_status_n_oe && $past(config_request_n, 3)) else $error("bad ready rise");
  AST_POR_LOW: assert property (config_status_n_oe [*2] |-> config_complete_oe)
    else $error("complete released in reset");
  AST_CELL_LATENCY: assert property ($rose(cfg_strobe) && config_ready && !compression_active
    |-> ##3 (cell_wr_en && cell_wr_data == $past(cfg_data, 3))) else $error("byte not written");
  AST_COMPRESS_SEL: assert property (compression_active |->
    scheme_code == CDP_SCH_AS || scheme_code == CDP_SCH_PS) else $error("bad expansion scheme");
  AST_REMOTE_INT: assert property (remote_update_internal |-> !remote_update_external &&
    (scheme_code == CDP_SCH_AS || scheme_code == CDP_SCH_AP)) else $error("bad remote scheme");
  AST_REMOTE_OFF: assert property (!remote_update_option [*4] |->
    !remote_update_internal && !remote_update_external) else $error("remote active when off");
  AST_CORE_DROP: assert property (!core_supply_ok [*6] |->
    config_status_n_oe && !config_ready) else $error("core brown-out missed");
  AST_PLL_DROP: assert property (!pll_supply_ok [*6] |->
    config_status_n_oe && !config_ready) else $error("pll brown-out missed");
  COV_READY: cover property ($rose(config_ready));
  COV_EXPAND: cover property (compression_active && cell_wr_en);
  COV_DONE: cover property ($fell(config_complete_oe));
endmodule : cdp_config_front_chk

bind cdp_config_front cdp_config_front_chk #(
  .FAST_POR_CYCLES(FAST_POR_CYCLES),
  .STD_POR_CYCLES (STD_POR_CYCLES),
  .DATA_W         (DATA_W)
) u_chk (
  .clk(clk), .nrst(nrst), .core_supply_ok(core_supply_ok), .pll_supply_ok(pll_supply_ok),
  .config_request_n(config_request_n), .remote_update_option(remote_update_option),
  .cfg_strobe(cfg_strobe), .cfg_data(cfg_data), .config_status_n_oe(config_status_n_oe),
  .config_complete_oe(config_complete_oe), .cell_wr_en(cell_wr_en),
  .cell_wr_data(cell_wr_data), .config_ready(config_ready), .por_fast(por_fast),
  .scheme_code(scheme_code), .compression_active(compression_active),
  .remote_update_internal(remote_update_internal),
  .remote_update_external(remote_update_external)
);

// ===== cdp_config_front_tb.sv
`timescale 1ns/1ps
module cdp_config_front_tb;
  import cdp_pkg::*;
  localparam int FAST = 20;
  localparam int STD  = 50;
  logic       clk, nrst, core, pll, io, req_n, rem, comp, send, slow, busy, strobe;
  logic       st_oe, st_out, cd_oe, cd_out, wr_en, ready, pf, c_act, c_ref, r_int, r_ext;
  logic       stray, bo, cm;
  logic [3:0] sel;
  logic [2:0] code, s;
  logic [7:0] hb, cdata, wr_data;
  logic [7:0] got[$];
  int         mismatches, checks, cyc, n, p;
  wire        status_pin = st_oe ? st_out : 1'b1;
  wire        done_pin   = cd_oe ? cd_out : 1'b1;
  logic [7:0] plain[8] = '{8'h5A, 8'h00, 8'h03, 8'h00, 8'h04, 8'hC3, 8'h7E, 8'h11};
  logic [7:0] cexp[8]  = '{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC3, 8'h7E};

  cdp_config_front #(.FAST_POR_CYCLES(FAST), .STD_POR_CYCLES(STD), .FRAME_BYTES(8)) uut (
    .clk(clk), .nrst(nrst), .core_supply_ok(core), .pll_supply_ok(pll),
    .io_bank_supply_ok(io), .scheme_select(sel), .config_request_n(req_n),
    .remote_update_option(rem), .compression_option(comp), .cfg_strobe(strobe),
    .cfg_data(cdata), .config_status_n_out(st_out), .config_status_n_oe(st_oe),
    .config_complete_out(cd_out), .config_complete_oe(cd_oe), .cell_wr_en(wr_en),
    .cell_wr_data(wr_data), .config_ready(ready), .por_fast(pf), .scheme_code(code),
    .compression_active(c_act), .compression_refused(c_ref),
    .remote_update_internal(r_int), .remote_update_external(r_ext),
    .brownout_seen(bo), .stray_data(stray));

  cdp_host_model host (.clk(clk), .nrst(nrst), .send(send), .slow(slow), .byte_in(hb),
    .cfg_strobe(strobe), .cfg_data(cdata), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) if (wr_en === 1'b1) got.push_back(wr_data);

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task send_byte(input logic [7:0] b);
    send <= 1'b1;
    hb   <= b;
    @(posedge clk);
    send <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
  endtask : send_byte

  task wait_ready(output int c);
    c = 0;
    while (ready !== 1'b1 && c < 300) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_ready

  task run_frame(input int nb, input logic c);
    got.delete();
    for (int k = 0; k < nb; k++) send_byte(plain[k]);
    repeat (4) @(posedge clk);
    chk(got.size() == 8, "write count");
    for (int k = 0; k < 8; k++) chk(got[k] === (c ? cexp[k] : plain[k]), "cell data");
    chk(done_pin === 1'b1, "complete not released");
  endtask : run_frame

  task end_sim();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    nrst = 1'b0; core = 1'b0; pll = 1'b0; io = 1'b0; req_n = 1'b0; rem = 1'b1;
    comp = 1'b1; sel = 4'h8; send = 1'b0; slow = 1'b0; hb = 8'h00;
    repeat (20) @(posedge clk);
    chk(status_pin === 1'b0 && done_pin === 1'b0, "pins high in reset");
    nrst <= 1'b1;
    core <= 1'b1;
    pll  <= 1'b1;
    repeat (60) @(posedge clk);
    chk(status_pin === 1'b0, "released without io supply");
    io <= 1'b1;
    repeat (80) @(posedge clk);
    chk(status_pin === 1'b0 && ready === 1'b0, "released under request");
    req_n <= 1'b1;
    wait_ready(n);
    chk(n <= 6 && status_pin === 1'b1, "no release on request");
    run_frame(7, 1'b1);
    // Each pass re-runs power-up through a brown-out, so the strap is taken afresh.
    for (int i = 0; i < 10; i++) begin
      s = 3'(i % 5);
      p = (i == 4) ? STD : FAST;
      cm = (i != 5) && (s == 3'h0 || s == 3'h2);
      sel  <= {i != 4, s};
      rem  <= i < 5;
      comp <= i != 5;
      {core, pll} <= i[0] ? 2'b10 : 2'b01;
      repeat (8) @(posedge clk);
      chk(status_pin === 1'b0 && done_pin === 1'b0 && bo === 1'b1, "brown-out");
      {core, pll} <= 2'b11;
      wait_ready(n);
      chk(n > p && n < p + 12, "reset time");
      chk(bo === 1'b0 && stray === 1'b0, "sticky flags not cleared");
      chk(code === s && pf === (i != 4), "strap");
      chk(c_act === cm && c_ref === (i != 5 && !cm), "compression mode");
      chk(r_int === (i < 5 && s < 3'h2), "remote internal");
      chk(r_ext === (i < 5 && (s == 3'h2 || s == 3'h3)), "remote external");
      io <= 1'b0;
      repeat (10) @(posedge clk);
      chk(ready === 1'b1 && status_pin === 1'b1, "io drop acted on");
      io   <= 1'b1;
      slow <= i[0];
      run_frame(cm ? 7 : 8, cm);
    end
    got.delete();
    send_byte(8'h33);
    repeat (4) @(posedge clk);
    chk(stray === 1'b1 && got.size() == 0, "stray byte");
    req_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk(status_pin === 1'b0 && done_pin === 1'b0 && ready === 1'b0, "request low ignored");
    req_n <= 1'b1;
    wait_ready(n);
    chk(n <= 6 && status_pin === 1'b1 && stray === 1'b0, "no reconfiguration");
    run_frame(8, 1'b0);
    end_sim();
  end
endmodule : cdp_config_front_tb
